// ==== core/mdb_mul_div_block.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mdb_defs.vh"

// Behaviour
// [RULE1] own pipeline keeps advancing whatever the integer pipe does; no integer-pipe stall input; the code freezes all state, divide included, while ce is low
// [RULE2] booth-recoded 32x16 array, upper/bottom result pair, divide state machine
// [RULE3] pass count chosen from right operand only
// [RULE4] right operand fitting 16 bits: one pass; otherwise two passes
// [RULE5] narrow multiplies every cycle, full-width multiplies every second cycle
// [RULE6] back-to-back full-width multiplies: interlock stalls the second issue
// [RULE7] operand width class detected by hardware, no instruction field
// [RULE8] divide iterates, one quotient bit per clock
// [RULE9] dividend fitting 8/16/24 bits skips 23/15/7 iterations
// [RULE10] further issue while divide active stalls until divide finishes
// [RULE11] pair-writing multiplies: latency 1 repeat 1 narrow, latency 2 repeat 2 wide
// [RULE12] register-writing multiply: latency 2 repeat 1 narrow, latency 3 repeat 2 wide
// [RULE13] divide latency 12/19/26/33, repeat 11/18/25/32 by dividend width
// [RULE14] accumulate adds/subtracts product to pair; others overwrite pair; the code leaves the pair unchanged on a register-writing multiply
module mdb_mul_div_block (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire issue_valid,
  input wire [2:0] issue_op,
  input wire issue_signed,
  input wire [31:0] dividend_left_operand,
  input wire [31:0] right_operand,
  output wire issue_stall,
  output wire issue_taken,
  output reg [31:0] upper_result_word,
  output reg [31:0] bottom_result_word,
  output reg pair_update,
  output reg gpr_valid,
  output reg [31:0] gpr_result,
  output wire div_busy
);

  localparam ST_IDLE = 2'b01;
  localparam ST_DIV = 2'b10;

  // does v fit n bits (sign- or zero-extended)
  function fits_n;
    input [31:0] v;
    input sgn;
    input integer n;
    integer i;
    begin
      fits_n = 1'b1;
      for (i = 0; i < 32; i = i + 1) begin
        if (i >= n && v[i] != (sgn ? v[n-1] : 1'b0))
          fits_n = 1'b0;
      end
    end
  endfunction

  // radix-4 booth: signed 33-bit by signed 17-bit
  function [49:0] booth_pass;
    input [32:0] a;
    input [16:0] b;
    reg [18:0] bx;
    reg [49:0] acc;
    reg [49:0] ax;
    integer d;
    begin
      bx = {b[16], b, 1'b0};
      acc = 50'h0;
      ax = {{17{a[32]}}, a};
      for (d = 0; d < 9; d = d + 1) begin
        case (bx[2*d +: 3])
          3'b001, 3'b010: acc = acc + (ax << (2*d));
          3'b011: acc = acc + (ax << (2*d+1));
          3'b100: acc = acc - (ax << (2*d+1));
          3'b101, 3'b110: acc = acc - (ax << (2*d));
          default: acc = acc;
        endcase
      end
      booth_pass = acc;
    end
  endfunction

  reg [1:0] state_r;
  reg wide_r;
  reg [2:0] wide_op_r;
  reg [32:0] wide_left_r;
  reg [16:0] wide_hi_r;
  reg [63:0] wide_lo_r;
  reg gpr_pend_r;
  reg [31:0] gpr_stage_r;
  reg [5:0] cnt_r;
  reg [5:0] iter_r;
  reg [31:0] quo_r;
  reg [32:0] rem_r;
  reg [31:0] dvsr_r;
  reg neg_q_r;
  reg neg_r_r;

  wire is_div = (issue_op == `MDB_OP_QUOTIENT);
  // narrow class decided from right operand alone
  wire narrow = fits_n(right_operand, issue_signed, `MDB_NARROW_BITS); // [RULE3] [RULE7]
  wire [32:0] left_x = {issue_signed & dividend_left_operand[31], dividend_left_operand};

  // divide still short of its final cycle; a wide second pass stalls through wide_r instead
  assign div_busy = state_r[1] && (cnt_r > 6'h01);
  assign issue_stall = issue_valid && (wide_r || div_busy); // [RULE5] [RULE6] [RULE10]
  assign issue_taken = issue_valid && ce && !issue_stall;

  wire mul_take = issue_taken && !is_div;
  wire div_take = issue_taken && is_div;

  // single pass: narrow full product, or low half of a wide one
  wire [16:0] pass_b = narrow ? right_operand[16:0] : {1'b0, right_operand[15:0]}; // [RULE4]
  wire [49:0] pass_p = booth_pass(left_x, pass_b); // [RULE2]
  wire [63:0] pass_x = {{14{pass_p[49]}}, pass_p};
  wire [49:0] hi_p = booth_pass(wide_left_r, wide_hi_r);
  wire [63:0] hi_x = {{14{hi_p[49]}}, hi_p};
  wire [63:0] wide_prod = wide_lo_r + (hi_x << `MDB_HALF_SHIFT); // [RULE4]

  // final product this edge: narrow issue or second pass
  wire prod_done = (mul_take && narrow) || wide_r;
  wire [2:0] prod_op = wide_r ? wide_op_r : issue_op;
  wire [63:0] prod = wide_r ? wide_prod : pass_x;
  wire [63:0] pair;

  reg [63:0] pair_mul;
  always @* begin
    case (prod_op) // [RULE14]
      `MDB_OP_ADD_ACCUM: pair_mul = pair + prod;
      `MDB_OP_SUB_ACCUM: pair_mul = pair - prod;
      default: pair_mul = prod;
    endcase
  end

  // divide setup: width class from dividend sign or zero extension
  wire [31:0] dvd_mag = (issue_signed && dividend_left_operand[31]) ? (32'h0 - dividend_left_operand)
                                                                  : dividend_left_operand;
  wire [31:0] dvs_mag = (issue_signed && right_operand[31]) ? (32'h0 - right_operand) : right_operand;
  reg [5:0] skip;
  reg [5:0] rep;
  always @* begin
    if (fits_n(dividend_left_operand, issue_signed, `MDB_DIV_W8)) begin // [RULE9]
      skip = `MDB_SKIP_W8;
      rep = `MDB_DIV_REP_W8;
    end else if (fits_n(dividend_left_operand, issue_signed, `MDB_DIV_W16)) begin
      skip = `MDB_SKIP_W16;
      rep = `MDB_DIV_REP_W16;
    end else if (fits_n(dividend_left_operand, issue_signed, `MDB_DIV_W24)) begin
      skip = `MDB_SKIP_W24;
      rep = `MDB_DIV_REP_W24;
    end else begin
      skip = `MDB_SKIP_W32;
      rep = `MDB_DIV_REP_W32;
    end
  end

  // one restoring step per clock
  wire [32:0] rem_sh = {rem_r[31:0], quo_r[31]};
  wire rem_ge = (rem_sh >= {1'b0, dvsr_r});
  wire step = state_r[1] && (iter_r != 6'h00);
  wire [32:0] rem_nxt = step ? (rem_ge ? rem_sh - {1'b0, dvsr_r} : rem_sh) : rem_r; // [RULE8]
  wire [31:0] quo_nxt = step ? {quo_r[30:0], rem_ge} : quo_r;
  wire div_fin = state_r[1] && (cnt_r == 6'h01);
  wire [31:0] q_out = neg_q_r ? (32'h0 - quo_nxt) : quo_nxt;
  wire [31:0] r_out = neg_r_r ? (32'h0 - rem_nxt[31:0]) : rem_nxt[31:0];
  // an accumulate taken in a divide's last cycle must build on the divide result, not the stale pair
  assign pair = div_fin ? {r_out, q_out} : {upper_result_word, bottom_result_word}; // [RULE14]

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      wide_r <= 1'b0;
      wide_op_r <= 3'h0;
      wide_left_r <= 33'h0;
      wide_hi_r <= 17'h0;
      wide_lo_r <= 64'h0;
      gpr_pend_r <= 1'b0;
      gpr_stage_r <= 32'h0;
      gpr_valid <= 1'b0;
      gpr_result <= 32'h0;
      upper_result_word <= 32'h0;
      bottom_result_word <= 32'h0;
      pair_update <= 1'b0;
      cnt_r <= 6'h00;
      iter_r <= 6'h00;
      quo_r <= 32'h0;
      rem_r <= 33'h0;
      dvsr_r <= 32'h0;
      neg_q_r <= 1'b0;
      neg_r_r <= 1'b0;
    end else if (ce) begin // [RULE1]
      // wide multiply: hold operands for the second pass
      wide_r <= mul_take && !narrow; // [RULE4] [RULE6]
      if (mul_take && !narrow) begin
        wide_op_r <= issue_op;
        wide_left_r <= left_x;
        wide_hi_r <= {issue_signed & right_operand[31], right_operand[31:16]};
        wide_lo_r <= pass_x;
      end
      // register destination takes one extra stage
      gpr_pend_r <= prod_done && (prod_op == `MDB_OP_GPR_MUL); // [RULE12]
      gpr_stage_r <= prod[31:0];
      gpr_valid <= gpr_pend_r;
      if (gpr_pend_r)
        gpr_result <= gpr_stage_r;
      // an accumulate ending with a divide folds the divide result in through pair; an into-pair multiply drops it
      pair_update <= 1'b0;
      if (prod_done && prod_op != `MDB_OP_GPR_MUL) begin // [RULE11] [RULE14]
        upper_result_word <= pair_mul[63:32];
        bottom_result_word <= pair_mul[31:0];
        pair_update <= 1'b1;
      end else if (div_fin) begin // [RULE13] [RULE14]
        upper_result_word <= r_out;
        bottom_result_word <= q_out;
        pair_update <= 1'b1;
      end
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      if (step)
        iter_r <= iter_r - 6'h01;
      case (state_r)
        ST_IDLE: begin
          if (div_take) begin
            state_r <= ST_DIV;
            cnt_r <= rep; // [RULE13]
            iter_r <= `MDB_ITER_FULL - skip; // [RULE9]
            quo_r <= dvd_mag << skip;
            rem_r <= 33'h0;
            dvsr_r <= dvs_mag;
            neg_q_r <= issue_signed && (dividend_left_operand[31] ^ right_operand[31]);
            neg_r_r <= issue_signed && dividend_left_operand[31];
          end
        end
        ST_DIV: begin
          cnt_r <= cnt_r - 6'h01;
          if (div_fin) begin
            // divide may be re-issued in its final cycle
            if (div_take) begin
              cnt_r <= rep;
              iter_r <= `MDB_ITER_FULL - skip;
              quo_r <= dvd_mag << skip;
              rem_r <= 33'h0;
              dvsr_r <= dvs_mag;
              neg_q_r <= issue_signed && (dividend_left_operand[31] ^ right_operand[31]);
              neg_r_r <= issue_signed && dividend_left_operand[31];
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // mdb_mul_div_block

`default_nettype wire

// ==== shared/mdb_defs.vh ====
`ifndef MDB_DEFS_VH
`define MDB_DEFS_VH

// operation codes on issue_op
`define MDB_OP_INTO_PAIR 3'h0
`define MDB_OP_ADD_ACCUM 3'h1
`define MDB_OP_SUB_ACCUM 3'h2
`define MDB_OP_QUOTIENT 3'h3
`define MDB_OP_GPR_MUL 3'h4

// right operand width that still takes one pass through the array
`define MDB_NARROW_BITS 16
`define MDB_HALF_SHIFT 16

// dividend width classes and skipped iterations
`define MDB_DIV_W8 8
`define MDB_DIV_W16 16
`define MDB_DIV_W24 24
`define MDB_SKIP_W8 6'h17
`define MDB_SKIP_W16 6'h0F
`define MDB_SKIP_W24 6'h07
`define MDB_SKIP_W32 6'h00
`define MDB_ITER_FULL 6'h20

// divide repeat rates in pipeline clocks; latency is one more
`define MDB_DIV_REP_W8 6'h0B
`define MDB_DIV_REP_W16 6'h12
`define MDB_DIV_REP_W24 6'h19
`define MDB_DIV_REP_W32 6'h20

`endif

// ==== sim/mdb_chk_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mdb_defs.vh"
module mdb_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire logic [2:0] issue_op,
  input wire logic issue_signed,
  input wire logic [31:0] dividend_left_operand,
  input wire logic [31:0] right_operand,
  input wire logic issue_stall,
  input wire logic issue_taken,
  input wire logic pair_update,
  input wire logic gpr_valid,
  input wire logic div_busy
);
  wire logic nrw;
  wire logic fit8;
  wire logic pop;
  wire logic gop;
  assign nrw = issue_signed ? (&right_operand[31:15] | ~|right_operand[31:15]) : ~|right_operand[31:16];
  assign fit8 = issue_signed ? (&dividend_left_operand[31:7] | ~|dividend_left_operand[31:7])
    : ~|dividend_left_operand[31:8];
  assign pop = issue_op < `MDB_OP_QUOTIENT;
  assign gop = issue_op == `MDB_OP_GPR_MUL;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_stall_qual: assert property (issue_stall |-> issue_valid)
    else $error("stall without an offered issue");
  chk_pair_narrow: assert property (issue_taken && pop && nrw |=> pair_update)
    else $error("narrow pair result late");
  chk_pair_wide: assert property (issue_taken && pop && !nrw |-> ##2 pair_update)
    else $error("wide pair result late");
  chk_wide_lock: assert property (issue_taken && (pop || gop) && !nrw |=> !issue_taken)
    else $error("wide multiply reissued too soon");
  chk_gpr_narrow: assert property (issue_taken && gop && nrw |-> ##2 gpr_valid)
    else $error("narrow register product late");
  chk_gpr_wide: assert property (issue_taken && gop && !nrw |-> ##3 gpr_valid)
    else $error("wide register product late");
  chk_div_hold: assert property (issue_taken && issue_op == `MDB_OP_QUOTIENT |=> (div_busy && !issue_taken)[*8])
    else $error("issue accepted during divide");
  chk_div_quick: assert property (issue_taken && issue_op == `MDB_OP_QUOTIENT && fit8 |-> ##12 pair_update)
    else $error("short divide result late");
endmodule // mdb_chk
bind mdb_mul_div_block mdb_chk u_chk (.clk, .rst, .issue_valid, .issue_op, .issue_signed, .dividend_left_operand,
  .right_operand, .issue_stall, .issue_taken, .pair_update, .gpr_valid, .div_busy);
`default_nettype wire

// ==== sim/mdb_int_pipe.sv ====
`timescale 1ns/1ps
`default_nettype none
module mdb_int_pipe (
  input wire logic clk,
  input wire logic issue_taken,
  output logic issue_valid,
  output logic [2:0] issue_op,
  output logic issue_signed,
  output logic [31:0] opa,
  output logic [31:0] opb
);
  initial begin
    issue_valid = 1'b0;
    issue_op = 3'h0;
    issue_signed = 1'b0;
    opa = 32'h0;
    opb = 32'h0;
  end
  // entered at a rising edge; request held until taken, so chaining needs no gap
  task automatic issue(input logic [2:0] op, input logic sg, input logic [31:0] a, b, output int stalls);
    stalls = 0;
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_signed <= sg;
    opa <= a;
    opb <= b;
    @(negedge clk);
    while (issue_taken !== 1'b1 && stalls < 40) begin
      stalls++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  // released operands flip so stale values never look valid
  task automatic idle();
    issue_valid <= 1'b0;
    opa <= ~opa;
    opb <= ~opb;
  endtask
endmodule // mdb_int_pipe
`default_nettype wire

// ==== sim/mdb_mul_div_block_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module mdb_mul_div_block_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic issue_valid, issue_signed, issue_stall, issue_taken, pair_update, gpr_valid, div_busy;
  logic [2:0] issue_op;
  logic [31:0] opa, opb, upper_result_word, bottom_result_word, gpr_result;
  int mismatches = 0;
  int num_checks = 0;
  int st;
  int n;
  always #5 clk = ~clk;
  mdb_mul_div_block dut (.clk(clk), .rst(rst), .ce(ce), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_signed(issue_signed), .dividend_left_operand(opa), .right_operand(opb), .issue_stall(issue_stall),
    .issue_taken(issue_taken), .upper_result_word(upper_result_word), .bottom_result_word(bottom_result_word),
    .pair_update(pair_update), .gpr_valid(gpr_valid), .gpr_result(gpr_result), .div_busy(div_busy));
  mdb_int_pipe pipe (.clk(clk), .issue_taken(issue_taken), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_signed(issue_signed), .opa(opa), .opb(opb));
  task automatic check(input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cycles from the issue edge to the result pulse, counted at falling edges
  task automatic lat(input logic gpr, output int c);
    c = 1;
    @(negedge clk);
    while ((gpr ? gpr_valid : pair_update) !== 1'b1) begin
      c++;
      if (c > 40) begin
        mismatches++;
        report_and_stop();
      end
      @(negedge clk);
    end
  endtask
  task automatic t_pair();
    logic [2:0] op[4] = '{3'h0, 3'h1, 3'h2, 3'h2};
    logic [31:0] a[4] = '{32'h7, 32'h7, 32'h7, 32'hFFFFFFFF};
    logic [63:0] e[4] = '{64'h15, 64'h2A, 64'h15, 64'h18};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pipe.issue(op[i], i == 3, a[i], 32'h3, st);
      pipe.idle();
      check(st, 0);
      lat(1'b0, n);
      check(n, 1);
      check({upper_result_word, bottom_result_word}, e[i]);
    end
  endtask
  task automatic t_wide();
    @(posedge clk);
    pipe.issue(3'h0, 1'b0, 32'h5, 32'h3, st);
    pipe.issue(3'h1, 1'b0, 32'h2, 32'h2, st);
    pipe.idle();
    check(st, 0);
    lat(1'b0, n);
    check(n, 1);
    check({upper_result_word, bottom_result_word}, 64'h13);
    @(posedge clk);
    pipe.issue(3'h0, 1'b0, 32'hFFFFFFFF, 32'h10000, st);
    pipe.issue(3'h0, 1'b0, 32'h12345678, 32'h9ABCDEF0, st);
    pipe.idle();
    check(st, 1);
    lat(1'b0, n);
    check(n, 2);
    check({upper_result_word, bottom_result_word}, 64'h12345678 * 64'h9ABCDEF0);
  endtask
  task automatic t_gpr();
    logic [63:0] keep;
    keep = {upper_result_word, bottom_result_word};
    @(posedge clk);
    pipe.issue(3'h4, 1'b1, 32'hFFFFFFFA, 32'h7, st);
    pipe.idle();
    lat(1'b1, n);
    check(n, 2);
    check(gpr_result, 32'hFFFFFFD6);
    @(posedge clk);
    pipe.issue(3'h4, 1'b0, 32'h3, 32'h20000, st);
    pipe.idle();
    lat(1'b1, n);
    check(n, 3);
    check(gpr_result, 32'h60000);
    check({upper_result_word, bottom_result_word}, keep);
  endtask
  task automatic t_div();
    logic [31:0] a[5] = '{32'd100, 32'h1234, 32'h123456, 32'h12345678, 32'hFFFFFF9C};
    int rep[5] = '{11, 18, 25, 32, 11};
    logic sg;
    for (int i = 0; i < 5; i++) begin
      sg = i == 4;
      @(posedge clk);
      pipe.issue(3'h3, sg, a[i], 32'h7, st);
      // a following op is held off until the divide's repeat point
      pipe.issue(3'h4, 1'b0, 32'h1, 32'h1, st);
      pipe.idle();
      check(st, rep[i] - 1);
      lat(1'b0, n);
      check(n, 1);
      check({upper_result_word, bottom_result_word}, sg ? {32'($signed(a[i]) % 7), 32'($signed(a[i]) / 7)}
        : {a[i] % 32'h7, a[i] / 32'h7});
    end
  endtask
  // clock enable low mid-divide: all state holds, so the stall stretches by the frozen cycles
  task automatic t_freeze();
    @(posedge clk);
    pipe.issue(3'h3, 1'b0, 32'h1234, 32'h7, st);
    fork
      pipe.issue(3'h1, 1'b0, 32'h1, 32'h1, st);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
      end
    join
    pipe.idle();
    check(st, 22);
    lat(1'b0, n);
    check(n, 1);
    check({upper_result_word, bottom_result_word}, {32'h1234 % 32'h7, 32'h1234 / 32'h7 + 32'h1});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_pair();
    t_wide();
    t_gpr();
    t_div();
    t_freeze();
    report_and_stop();
  end
endmodule // mdb_mul_div_block_tb
`default_nettype wire
